// *** verilog/host_timers_counters.sv ***
// Host-visible timer, free-running counter, dropped-frame counter and word-order register
`timescale 1ns/1ps
`default_nettype none
module host_timers_counters
  import sys_timers_pkg::*;
#(
  parameter int TICK_DIV = TIMER_TICK_CYCLES
) (
  input wire logic clk, // 25 MHz system clock
  input wire logic srst, // Synchronous reset, active high
  input wire logic cs_n, // Host chip select, active low
  input wire logic rd_n, // Host read strobe, active low
  input wire logic wr_n, // Host write strobe, active low
  input wire logic [sys_timers_pkg::HOST_ADDR_W-1:0] addr, // Host byte address bits 7..1
  input wire logic [sys_timers_pkg::HOST_DATA_W-1:0] wdata, // Host write data
  input wire logic rx_frame_dropped, // Pulse per discarded receive frame
  output logic [sys_timers_pkg::HOST_DATA_W-1:0] rdata, // Host read data
  output logic timer_event, // Timer interval event pulse
  output logic drop_midpoint_event, // Dropped counter midpoint pulse
  output logic host_half_swap // Word order reversed, for host FIFO ports
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic rd_q;
    logic wr_q;
    logic [15:0] rdata;
    logic run;
    logic [15:0] preload;
    logic [31:0] word_order;
    logic swap;
    logic [31:0] free_cnt;
    logic fr_hold;
    logic [31:0] fr_cap;
    logic [31:0] drop_cnt;
    logic drop_hold;
    logic [31:0] drop_cap;
    logic drop_mid;
    logic timer_evt;
  } regs_state_t;

  regs_state_t st;
  regs_state_t next_st;

  logic tick;
  logic [15:0] timer_count;
  logic timer_expired;

  // ------------------------------------------------------------
  // Timer datapath
  // ------------------------------------------------------------
  tick_divider #(
    .DIV(TICK_DIV)
  ) u_tick (
    .clk(clk),
    .srst(srst),
    .tick(tick)
  );

  gp_timer_core #(
    .W(TIMER_W)
  ) u_timer (
    .clk(clk),
    .srst(srst),
    .tick(tick),
    .run(st.run),
    .preload(st.preload),
    .count(timer_count),
    .expired(timer_expired)
  );

  // ------------------------------------------------------------
  // Host access decode
  // ------------------------------------------------------------
  logic rd_act;
  logic wr_act;
  logic rd_start;
  logic wr_start;
  logic [7:0] word_off;
  logic upper;

  assign rd_act = !cs_n && !rd_n;
  assign wr_act = !cs_n && !wr_n;
  // Only the first cycle of a strobe counts, so a long strobe is one access
  assign rd_start = rd_act && !st.rd_q;
  assign wr_start = wr_act && !st.wr_q && !rd_act;
  assign word_off = {addr[6:1], 2'b00};
  assign upper = addr[0] ^ st.swap;

  function automatic logic [15:0] pick(input logic [31:0] w, input logic hi);
    pick = hi ? w[31:16] : w[15:0];
  endfunction

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    logic [31:0] cfg_word;
    logic drop_inc;
    cfg_word = '0;
    drop_inc = 1'b0;
    next_st = st;
    next_st.rd_q = rd_act;
    next_st.wr_q = wr_act;
    next_st.drop_mid = 1'b0;
    next_st.timer_evt = timer_expired;
    next_st.swap = (st.word_order == WORD_ORDER_SWAP_KEY);

    // Runs every cycle; no power state input can gate it
    next_st.free_cnt = st.free_cnt + 32'h00000001;

    // Dropped frames; a frame in the clearing cycle survives as a count of one
    drop_inc = rx_frame_dropped;
    if (drop_inc) begin
      next_st.drop_cnt = st.drop_cnt + 32'h00000001;
      if (st.drop_cnt == DROPPED_MIDPOINT - 32'h00000001) begin
        next_st.drop_mid = 1'b1;
      end
    end

    cfg_word = '0;
    cfg_word[TIMER_RUN_BIT] = st.run;
    cfg_word[15:0] = st.preload;

    if (rd_start) begin
      case (word_off)
        OFF_TIMER_CONFIG: next_st.rdata = pick(cfg_word, upper);
        OFF_TIMER_COUNT: next_st.rdata = pick({16'h0000, timer_count}, upper);
        OFF_WORD_ORDER: next_st.rdata = pick(st.word_order, upper);
        OFF_FREE_RUN: begin
          if (st.fr_hold) begin
            next_st.rdata = pick(st.fr_cap, upper);
            next_st.fr_hold = 1'b0;
          end else begin
            next_st.rdata = pick(st.free_cnt, upper);
            next_st.fr_cap = st.free_cnt;
            next_st.fr_hold = 1'b1;
          end
        end
        OFF_DROPPED: begin
          if (st.drop_hold) begin
            next_st.rdata = pick(st.drop_cap, upper);
            next_st.drop_hold = 1'b0;
          end else begin
            next_st.rdata = pick(st.drop_cnt, upper);
            next_st.drop_cap = st.drop_cnt;
            next_st.drop_hold = 1'b1;
            next_st.drop_cnt = drop_inc ? 32'h00000001 : DROPPED_RESET;
          end
        end
        default: next_st.rdata = 16'h0000;
      endcase
    end

    if (wr_start) begin
      case (word_off)
        OFF_TIMER_CONFIG: begin
          if (upper) begin
            next_st.run = wdata[TIMER_RUN_BIT_IN_HI];
            if (st.run && !wdata[TIMER_RUN_BIT_IN_HI]) begin
              next_st.preload = PRELOAD_RESET;
            end
          end else begin
            next_st.preload = wdata;
          end
        end
        OFF_WORD_ORDER: begin
          if (upper) begin
            next_st.word_order[31:16] = wdata;
          end else begin
            next_st.word_order[15:0] = wdata;
          end
        end
        // Count, free-run and dropped registers ignore writes
        default: begin
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      st.rd_q <= 1'b0;
      st.wr_q <= 1'b0;
      st.rdata <= 16'h0000;
      st.run <= 1'b0;
      st.preload <= PRELOAD_RESET;
      st.word_order <= WORD_ORDER_RESET;
      st.swap <= 1'b0;
      st.free_cnt <= FREE_RUN_RESET;
      st.fr_hold <= 1'b0;
      st.fr_cap <= FREE_RUN_RESET;
      st.drop_cnt <= DROPPED_RESET;
      st.drop_hold <= 1'b0;
      st.drop_cap <= DROPPED_RESET;
      st.drop_mid <= 1'b0;
      st.timer_evt <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign rdata = st.rdata;
  assign timer_event = st.timer_evt;
  assign drop_midpoint_event = st.drop_mid;
  // FIFO lane mapping follows this only on the host side; the network path
  // keeps the lower half first whatever the host order is
  assign host_half_swap = st.swap;
endmodule
`default_nettype wire

// *** verilog/sys_timers_pkg.sv ***
// Shared offsets, field layout, reset values and timing for the host timer registers
package sys_timers_pkg;
  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_TIMER_CONFIG = 8'h8c;
  localparam logic [7:0] OFF_TIMER_COUNT = 8'h90;
  localparam logic [7:0] OFF_WORD_ORDER = 8'h98;
  localparam logic [7:0] OFF_FREE_RUN = 8'h9c;
  localparam logic [7:0] OFF_DROPPED = 8'ha0;

  // ------------------------------------------------------------
  // Field positions and widths
  // ------------------------------------------------------------
  localparam int HOST_ADDR_W = 7;
  localparam int HOST_DATA_W = 16;
  localparam int TIMER_W = 16;
  localparam int TIMER_RUN_BIT = 29;
  localparam int TIMER_RUN_BIT_IN_HI = TIMER_RUN_BIT - 16;

  // ------------------------------------------------------------
  // Reset and special values
  // ------------------------------------------------------------
  localparam logic [15:0] PRELOAD_RESET = 16'hffff;
  localparam logic [15:0] COUNT_RESET = 16'hffff;
  localparam logic [31:0] WORD_ORDER_RESET = 32'h00000000;
  localparam logic [31:0] WORD_ORDER_SWAP_KEY = 32'hffffffff;
  localparam logic [31:0] FREE_RUN_RESET = 32'h00000000;
  localparam logic [31:0] DROPPED_RESET = 32'h00000000;
  localparam logic [31:0] DROPPED_MIDPOINT = 32'h80000000;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int TIMER_TICK_NS = 1000;
  localparam int TIMER_TICK_CYCLES = (TIMER_TICK_NS * (CLK_HZ / 1000000) + 999) / 1000;
endpackage

// *** verilog/tick_divider.sv ***
// Divider producing a one-cycle timer tick enable
`timescale 1ns/1ps
`default_nettype none
module tick_divider
  import sys_timers_pkg::*;
#(
  parameter int DIV = TIMER_TICK_CYCLES
) (
  input wire logic clk, // System clock
  input wire logic srst, // Synchronous reset
  output logic tick // One-cycle tick pulse
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } div_state_t;

  div_state_t st;
  div_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.cnt == LAST) begin
      next_st.cnt = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;
endmodule
`default_nettype wire

// *** verilog/gp_timer_core.sv ***
// Reloading down-counter of the general-purpose timer
`timescale 1ns/1ps
`default_nettype none
module gp_timer_core
  import sys_timers_pkg::*;
#(
  parameter int W = TIMER_W
) (
  input wire logic clk, // System clock
  input wire logic srst, // Synchronous reset
  input wire logic tick, // Timer tick enable
  input wire logic run, // Run enable level
  input wire logic [W-1:0] preload, // Reload value
  output logic [W-1:0] count, // Present count
  output logic expired // One-cycle interval event
);
  typedef struct packed {
    logic run_q;
    logic [W-1:0] count;
    logic expired;
  } tmr_state_t;

  tmr_state_t st;
  tmr_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.run_q = run;
    next_st.expired = 1'b0;
    if (run && !st.run_q) begin
      next_st.count = preload;
    end else if (run && tick) begin
      if (st.count == '0) begin
        next_st.count = preload;
        next_st.expired = 1'b1;
      end else begin
        next_st.count = st.count - W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st.run_q <= 1'b0;
      st.count <= W'(COUNT_RESET);
      st.expired <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign count = st.count;
  assign expired = st.expired;
endmodule
`default_nettype wire

// *** tb/host_timers_counters_monitor.sv ***
// Checker bound to the host timer register block
`timescale 1ns/1ps
`default_nettype none
module host_timers_counters_monitor
  import sys_timers_pkg::*;
#(
  parameter int TICK_DIV = TIMER_TICK_CYCLES
) (
  input wire logic clk, // Clock
  input wire logic srst, // Reset
  input wire logic cs_n, // Select
  input wire logic rd_n, // Read strobe
  input wire logic wr_n, // Write strobe
  input wire logic [sys_timers_pkg::HOST_ADDR_W-1:0] addr, // Address
  input wire logic [sys_timers_pkg::HOST_DATA_W-1:0] wdata, // Write data
  input wire logic rx_frame_dropped, // Drop pulse
  input wire logic [sys_timers_pkg::HOST_DATA_W-1:0] rdata, // Read data
  input wire logic timer_event, // Timer event
  input wire logic drop_midpoint_event, // Midpoint event
  input wire logic host_half_swap // Swap level
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic is98;
  logic key98;
  assign is98 = !cs_n && !wr_n && addr[6:1] == OFF_WORD_ORDER[7:2];
  assign key98 = is98 && wdata == 16'hffff;
  AST_EVT_GAP: assert property (timer_event |=> !timer_event ##1 !timer_event)
    else $error("timer event too close");
  AST_MID_PULSE: assert property (drop_midpoint_event |=> !drop_midpoint_event)
    else $error("midpoint event not a pulse");
  AST_MID_CAUSE: assert property (drop_midpoint_event |->
    $past(rx_frame_dropped) || $past(rx_frame_dropped, 2)) else $error("midpoint no drop");
  AST_SWAP_RISE: assert property ($rose(host_half_swap) |-> $past(key98) || $past(key98, 2))
    else $error("swap rose without key write");
  AST_SWAP_FALL: assert property ($fell(host_half_swap) |-> $past(is98) || $past(is98, 2))
    else $error("swap fell without write");
  AST_SWAP_STABLE: assert property (!$past(is98) && !$past(is98, 2) |-> $stable(host_half_swap))
    else $error("swap changed alone");
  AST_RDATA_HOLD: assert property (rd_n && $past(rd_n) |-> $stable(rdata))
    else $error("read data changed without read");
  AST_RESET_CLEAR: assert property (disable iff (1'b0) srst |=> rdata == 16'h0000 &&
    !timer_event && !drop_midpoint_event && !host_half_swap) else $error("reset state wrong");
  cover property (timer_event);
  cover property ($rose(host_half_swap));
  cover property (rx_frame_dropped ##1 !rd_n);
endmodule
bind host_timers_counters host_timers_counters_monitor #(.TICK_DIV(TICK_DIV)) mon_u (.clk(clk),
  .srst(srst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .wdata(wdata),
  .rx_frame_dropped(rx_frame_dropped), .rdata(rdata), .timer_event(timer_event),
  .drop_midpoint_event(drop_midpoint_event), .host_half_swap(host_half_swap));
`default_nettype wire

// *** tb/host_cpu_model.sv ***
// Host processor model for the SRAM-like register bus
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model (
  input wire logic clk, // Clock
  input wire logic [15:0] rdata, // Read data
  output logic cs_n, // Select
  output logic rd_n, // Read strobe
  output logic wr_n, // Write strobe
  output logic [6:0] addr, // Address
  output logic [15:0] wdata // Write data
);
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    addr = 7'h00;
    wdata = 16'h0000;
  end
  // Released lines show the inverse so stale values never pass
  task wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge clk);
    {cs_n, wr_n, addr, wdata} <= {2'b00, a, d};
    @(posedge clk);
    {cs_n, wr_n, addr, wdata} <= {2'b11, ~a, ~d};
  endtask
  // Each half read is a separate strobe; pairs are issued back to back
  task rd(input logic [6:0] a, output logic [15:0] d);
    @(posedge clk);
    {cs_n, rd_n, addr} <= {2'b00, a};
    @(posedge clk);
    {cs_n, rd_n, addr} <= {2'b11, ~a};
    @(posedge clk);
    d = rdata;
  endtask
endmodule
`default_nettype wire

// *** tb/host_timers_counters_tb_top.sv ***
// Self-checking bench for the host timer register block
`timescale 1ns/1ps
`default_nettype none
module host_timers_counters_tb_top;
  import sys_timers_pkg::*;
  localparam int DIV = 4;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic drop = 1'b0;
  logic cs_n, rd_n, wr_n, ev, mid, swp;
  logic [6:0] addr;
  logic [15:0] wdata, rdata, a, b, c, d;
  int mismatches = 0;
  int tests_run = 0;
  int cyc = 0;
  int n;
  logic mid_seen = 1'b0;
  always #20 clk = ~clk;
  host_cpu_model host_u (.clk(clk), .rdata(rdata), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .addr(addr), .wdata(wdata));
  host_timers_counters #(.TICK_DIV(DIV)) dut_u (.clk(clk), .srst(srst), .cs_n(cs_n),
    .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .wdata(wdata), .rx_frame_dropped(drop),
    .rdata(rdata), .timer_event(ev), .drop_midpoint_event(mid), .host_half_swap(swp));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wait_evt(output int k);
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (ev !== 1'b1 && k < 200);
  endtask
  task give_verdict();
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    // Sticky, so a one-cycle midpoint pulse cannot slip past the final check
    if (mid === 1'b1) mid_seen <= 1'b1;
    if (cyc == 20000) begin
      mismatches++;
      give_verdict();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    host_u.rd({OFF_TIMER_CONFIG[7:2], 1'b0}, a); chk(a, PRELOAD_RESET);
    host_u.rd({OFF_TIMER_CONFIG[7:2], 1'b1}, a); chk(a, 0);
    host_u.wr({OFF_TIMER_COUNT[7:2], 1'b0}, 16'h0000);
    host_u.rd({OFF_TIMER_COUNT[7:2], 1'b0}, a); chk(a, COUNT_RESET);
    host_u.rd({6'h2c, 1'b0}, a); chk(a, 0);
    host_u.wr({OFF_TIMER_CONFIG[7:2], 1'b0}, 16'h0003);
    host_u.wr({OFF_WORD_ORDER[7:2], 1'b0}, 16'hffff);
    host_u.wr({OFF_WORD_ORDER[7:2], 1'b1}, 16'hffff);
    // Swap follows the register one edge later; look once that edge has settled
    repeat (2) @(posedge clk); chk(swp, 1'b1);
    host_u.rd({OFF_TIMER_CONFIG[7:2], 1'b1}, a); chk(a, 16'h0003);
    host_u.rd({OFF_TIMER_CONFIG[7:2], 1'b0}, a); chk(a, 0);
    host_u.wr({OFF_WORD_ORDER[7:2], 1'b0}, 16'h0000);
    repeat (2) @(posedge clk); chk(swp, 1'b0);
    host_u.rd({OFF_TIMER_CONFIG[7:2], 1'b0}, a); chk(a, 16'h0003);
    host_u.wr({OFF_TIMER_CONFIG[7:2], 1'b1}, 16'h1 << TIMER_RUN_BIT_IN_HI);
    wait_evt(n);
    wait_evt(n); chk(n, 4 * DIV);
    host_u.wr({OFF_TIMER_CONFIG[7:2], 1'b1}, 16'h0000);
    host_u.rd({OFF_TIMER_CONFIG[7:2], 1'b0}, a); chk(a, 16'hffff);
    wait_evt(n); chk(n, 200);
    host_u.rd({OFF_FREE_RUN[7:2], 1'b0}, a);
    host_u.rd({OFF_FREE_RUN[7:2], 1'b1}, b);
    host_u.rd({OFF_FREE_RUN[7:2], 1'b0}, c);
    host_u.rd({OFF_FREE_RUN[7:2], 1'b1}, d);
    chk({d, c} - {b, a}, 32'd6);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk) drop <= 1'b1;
      @(posedge clk) drop <= 1'b0;
    end
    host_u.rd({OFF_DROPPED[7:2], 1'b0}, a); chk(a, 16'h0003);
    host_u.rd({OFF_DROPPED[7:2], 1'b1}, a); chk(a, 0);
    host_u.rd({OFF_DROPPED[7:2], 1'b0}, a); chk(a, 0);
    chk(mid_seen, 1'b0);
    give_verdict();
  end
endmodule
`default_nettype wire
